/* inc/isc_defs.vh */
// How it works
// - Acknowledge read returns vector, clears accepted flag
// - Program read of zero clears top pending flag
// - Both stack pointers reset to zero
// - No interrupt accepted during first instruction
// - Nonmaskable input accepted once first instruction is done, never disabled
// - Nonmaskable pin level readable as port bit
// - Nonmaskable low forces all-clock-stop bit zero
// - Wait with nonmaskable low halts, clock runs
// - Source change may spuriously set request flag
// - Write after protect unlock clears the unlock bit
// - Stop bit stops clocks; halt enters wait
// - Peripheral clocks stop in wait only if the wait peripheral clock stop bit is set, sub clock runs
// - Main oscillator stop disables crystal output only
// - Ports hold state during wait and stop
`ifndef ISC_DEFS_VH
`define ISC_DEFS_VH
`define ISC_ADDR_W 20
`define ISC_ADDR_ACK 20'h00000
`define ISC_ADDR_CC0 20'h00006
`define ISC_ADDR_CC1 20'h00007
`define ISC_ADDR_PRC 20'h0000A
`define ISC_ADDR_P8 20'h003F0
`define ISC_ADDR_USP 20'h00100
`define ISC_ADDR_ISP 20'h00102
`define ISC_ADDR_IRQ 20'h00104
`define ISC_ADDR_IEN 20'h00106
`define ISC_ADDR_IST 20'h00108
`define ISC_ADDR_ICLR 20'h0010A
`define ISC_ADDR_CFG 20'h0010C
`define ISC_BIT_WPCS 2
`define ISC_BIT_MOSC 5
`define ISC_BIT_ACS 0
`define ISC_BIT_PROTECT_UNLOCK_BIT 2
`define ISC_BIT_P85 5
`define ISC_SP_RST 16'h0000
`define ISC_NMI_VEC 8'hFF
`endif

/* src/isc_core.v */
`default_nettype none
`include "isc_defs.vh"
module isc_core #(
  parameter NSRC = 8
) (
  input wire core_clk, // CPU clock, 20 MHz
  input wire rstn, // Synchronous reset, active low
  input wire [`ISC_ADDR_W-1:0] addr, // Register address
  input wire [15:0] wdata, // Write data
  input wire wr, // Write strobe
  input wire rd, // Read strobe
  output reg [15:0] rdata, // Read data, cycle after rd
  input wire [NSRC-1:0] src_evt, // Peripheral request pulses
  input wire [NSRC-1:0] src_chg, // Source/polarity/timing changed
  input wire nmi_pin_n, // Nonmaskable pin, active low
  input wire insn_done, // CPU finished an instruction
  input wire halt_insn, // CPU executes halt
  input wire ack, // CPU interrupt acknowledge read
  input wire wake, // Standby exit by interrupt
  output wire irq_req, // Maskable request to CPU
  output wire nmi_req, // Nonmaskable request to CPU
  output reg [7:0] ack_vec_ff, // Accepted number/level
  output wire cpu_clk_en, // CPU clock gate
  output wire per_clk_en, // Peripheral clock gate
  output wire subdiv_clk_en, // Sub clock div32 gate
  output wire xout_en, // Crystal drive enable
  output wire port_hold, // Ports frozen in standby
  output wire stop_mode, // Stop mode active
  output wire wait_mode, // Wait mode active
  output wire int_out // Level interrupt of status
);
  reg [NSRC-1:0] irf_ff, ien_ff;
  reg [15:0] usp_ff, isp_ff;
  reg [7:0] cc0_ff, cc1_ff;
  reg protect_unlock_bit_ff, first_ff, wait_ff, nmi_s1_ff, nmi_s2_ff, nmi_d_ff;
  reg nmi_pend_ff;
  reg [2:0] st_ff, sen_ff;
  wire rd_ack = rd && addr == `ISC_ADDR_ACK;
  wire nmi_low = !nmi_s2_ff;
  wire nmi_fall = nmi_d_ff && !nmi_s2_ff;
  wire [NSRC-1:0] pend = irf_ff & ien_ff;

  // Lowest index wins; returns one-hot of the top pending request
  function [NSRC-1:0] top1;
    input [NSRC-1:0] v;
    begin
      top1 = v & (~v + {{(NSRC-1){1'b0}}, 1'b1});
    end
  endfunction

  function [7:0] enc;
    input [NSRC-1:0] oh;
    integer i;
    begin
      enc = 8'h00;
      for (i = 0; i < NSRC; i = i + 1) begin
        if (oh[i]) enc = i[7:0];
      end
    end
  endfunction

  wire [NSRC-1:0] sel = top1(pend);
  wire [NSRC-1:0] clr_acc = (ack || rd_ack) ? sel : {NSRC{1'b0}};
  wire [NSRC-1:0] clr_sw = (wr && addr == `ISC_ADDR_IRQ) ?
                           ~wdata[NSRC-1:0] : {NSRC{1'b0}};
  // Set wins over any clear in the same cycle
  wire [NSRC-1:0] nxt_irf = (irf_ff & ~clr_acc & ~clr_sw) | src_evt |
                            src_chg;

  assign irq_req = |pend && !first_ff;
  assign nmi_req = nmi_pend_ff && !first_ff;
  wire stop_req = cc1_ff[`ISC_BIT_ACS];
  assign stop_mode = stop_req;
  assign wait_mode = wait_ff;
  // With nonmaskable low, wait only halts the CPU, CPU clock keeps running
  assign cpu_clk_en = !stop_mode && !(wait_ff && !nmi_low);
  assign per_clk_en = !stop_mode &&
                      !(wait_ff && cc0_ff[`ISC_BIT_WPCS]);
  assign subdiv_clk_en = !stop_mode;
  assign xout_en = !cc0_ff[`ISC_BIT_MOSC] && !stop_mode;
  assign port_hold = stop_mode || wait_ff;

  // Status register: bit0 nmi edge, bit1 acknowledge, bit2 stop exit
  wire [2:0] evt = {stop_req && (wake || nmi_fall), ack || rd_ack,
                    nmi_fall};
  wire [2:0] sclr = (wr && addr == `ISC_ADDR_ICLR) ? wdata[2:0] : 3'h0;
  assign int_out = |(st_ff & sen_ff);

  always @(posedge core_clk) begin
    if (!rstn) begin
      irf_ff <= {NSRC{1'b0}};
      ien_ff <= {NSRC{1'b0}};
      usp_ff <= `ISC_SP_RST;
      isp_ff <= `ISC_SP_RST;
      cc0_ff <= 8'h00;
      cc1_ff <= 8'h00;
      protect_unlock_bit_ff <= 1'b0;
      first_ff <= 1'b1;
      wait_ff <= 1'b0;
      nmi_s1_ff <= 1'b1;
      nmi_s2_ff <= 1'b1;
      nmi_d_ff <= 1'b1;
      nmi_pend_ff <= 1'b0;
      st_ff <= 3'h0;
      sen_ff <= 3'h0;
      ack_vec_ff <= 8'h00;
      rdata <= 16'h0000;
    end else begin
      nmi_s1_ff <= nmi_pin_n;
      nmi_s2_ff <= nmi_s1_ff;
      nmi_d_ff <= nmi_s2_ff;
      irf_ff <= nxt_irf;
      st_ff <= (st_ff & ~sclr) | evt;
      if (insn_done) first_ff <= 1'b0;
      // Edge latched even in first instruction, taken right after
      if (nmi_fall) nmi_pend_ff <= 1'b1;
      else if (ack && !first_ff && nmi_pend_ff) nmi_pend_ff <= 1'b0;
      if (ack) ack_vec_ff <= nmi_pend_ff ? `ISC_NMI_VEC : enc(sel);
      if (halt_insn) wait_ff <= 1'b1;
      else if (wake || nmi_fall) wait_ff <= 1'b0;
      // Any write other than to the protect register spends the unlock, including the guarded one
      if (wr) begin
        protect_unlock_bit_ff <= (addr == `ISC_ADDR_PRC) ? wdata[`ISC_BIT_PROTECT_UNLOCK_BIT]
                                          : 1'b0;
      end
      if (wr && addr == `ISC_ADDR_USP) usp_ff <= wdata;
      if (wr && addr == `ISC_ADDR_ISP) isp_ff <= wdata;
      if (wr && addr == `ISC_ADDR_IEN) ien_ff <= wdata[NSRC-1:0];
      if (wr && addr == `ISC_ADDR_CFG) sen_ff <= wdata[2:0];
      if (wr && addr == `ISC_ADDR_CC0 && protect_unlock_bit_ff) cc0_ff <= wdata[7:0];
      if (nmi_low || (stop_req && wake)) begin
        cc1_ff[`ISC_BIT_ACS] <= 1'b0;
      end else if (wr && addr == `ISC_ADDR_CC1 && protect_unlock_bit_ff) begin
        cc1_ff <= wdata[7:0];
      end
      rdata <= 16'h0000;
      if (rd) begin
        case (addr)
          `ISC_ADDR_ACK: rdata <= {8'h00, enc(sel)};
          `ISC_ADDR_CC0: rdata <= {8'h00, cc0_ff};
          `ISC_ADDR_CC1: rdata <= {8'h00, cc1_ff};
          `ISC_ADDR_PRC: rdata <= {13'h0000, protect_unlock_bit_ff, 2'h0};
          `ISC_ADDR_P8: rdata <= {10'h000, nmi_s2_ff, 5'h00};
          `ISC_ADDR_USP: rdata <= usp_ff;
          `ISC_ADDR_ISP: rdata <= isp_ff;
          `ISC_ADDR_IRQ: rdata <= {{(16-NSRC){1'b0}}, irf_ff};
          `ISC_ADDR_IEN: rdata <= {{(16-NSRC){1'b0}}, ien_ff};
          `ISC_ADDR_IST: rdata <= {13'h0000, st_ff};
          `ISC_ADDR_CFG: rdata <= {13'h0000, sen_ff};
          default: rdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule // isc_core
`default_nettype wire

/* test/isc_props_properties.sv */
`default_nettype none
module isc_props (
  input wire core_clk, // CPU clock
  input wire rstn, // Sync reset
  input wire nmi_pin_n, insn_done, halt_insn, wake, // Causes
  input wire irq_req, nmi_req, cpu_clk_en, per_clk_en, // Effects
  input wire subdiv_clk_en, port_hold, stop_mode, wait_mode // Modes
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  reg run_ff; // Past the first instruction
  always @(posedge core_clk) run_ff <= rstn & (run_ff | insn_done);
  a_stop_nmi_low: assert property (!nmi_pin_n [*5] |-> !stop_mode)
    else $error("stop with nmi low");
  a_stop_gates: assert property (
    stop_mode |-> !cpu_clk_en && !per_clk_en) else $error("stop gates");
  a_halt_wait: assert property (halt_insn && !wake |=> wait_mode)
    else $error("no wait");
  a_ports_hold: assert property ((stop_mode || wait_mode) |-> port_hold)
    else $error("ports free");
  a_sub_runs: assert property (wait_mode |-> subdiv_clk_en)
    else $error("sub clock off");
  a_first_insn: assert property (
    $rose(rstn) |-> (!irq_req && !nmi_req) [*3]) else $error("early req");
  a_wake_exit: assert property (stop_mode && wake |=> !stop_mode)
    else $error("stop kept");
  a_nmi_taken: assert property (
    run_ff && $fell(nmi_pin_n) |-> ##[1:6] nmi_req) else $error("nmi lost");
  cover property (stop_mode);
  cover property (wait_mode && !nmi_pin_n);
  cover property (nmi_req);
endmodule // isc_props
bind isc_core isc_props u_props (.core_clk, .rstn, .nmi_pin_n, .insn_done,
  .halt_insn, .wake, .irq_req, .nmi_req, .cpu_clk_en, .per_clk_en,
  .subdiv_clk_en, .port_hold, .stop_mode, .wait_mode);
`default_nettype wire

/* test/isc_nmi_src.sv */
`default_nettype none
module isc_nmi_src #(parameter PH = 40) (
  input wire logic core_clk, // CPU clock
  input wire logic go, // Start one low phase
  output logic nmi_pin_n // Pin, pulled up when idle
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial nmi_pin_n = 1'b1;
  // PH must stay at 8 or more: two clocks plus 300 ns each phase
  always @(posedge core_clk) begin
    if (cnt != 0) cnt <= cnt - 1;
    else if (go) cnt <= 2 * PH;
    nmi_pin_n <= !(cnt > PH || (go && cnt == 0));
  end
endmodule // isc_nmi_src
`default_nettype wire

/* test/isc_core_tb.sv */
`default_nettype none
`include "isc_defs.vh"
module isc_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rstn = 0, wr = 0, rd = 0, go = 0, nmi_pin_n;
  logic ack = 0, insn_done = 0, halt_insn = 0, wake = 0;
  logic [`ISC_ADDR_W-1:0] addr = 0;
  logic [15:0] wdata = 0, rdata;
  logic [7:0] src_evt = 0, src_chg = 0, ack_vec_ff, r;
  logic irq_req, nmi_req, cpu_clk_en, per_clk_en, subdiv_clk_en;
  logic xout_en, port_hold, stop_mode, wait_mode, int_out;
  logic [31:0] seed = 61034;
  int failures = 0, checks_done = 0, i;
  always #25 core_clk = ~core_clk;
  isc_core dut (.core_clk, .rstn, .addr, .wdata, .wr, .rd, .rdata,
    .src_evt, .src_chg, .nmi_pin_n, .insn_done, .halt_insn, .ack, .wake,
    .irq_req, .nmi_req, .ack_vec_ff, .cpu_clk_en, .per_clk_en,
    .subdiv_clk_en, .xout_en, .port_hold, .stop_mode, .wait_mode, .int_out);
  isc_nmi_src nmi_src (.core_clk, .go, .nmi_pin_n);
  function automatic [7:0] first(input [7:0] v); // Lowest index wins
    first = 8'hFF;
    for (int k = 7; k >= 0; k--) if (v[k]) first = k[7:0];
  endfunction
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task wrr(input [19:0] a, input [15:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge core_clk);
    wr <= 0;
    #1;
  endtask
  task rdc(input [19:0] a, input logic [15:0] e);
    @(posedge core_clk);
    addr <= a;
    rd <= 1;
    @(posedge core_clk);
    rd <= 0;
    #1 if (e !== 16'hXXXX) chk(rdata, e);
  endtask
  task pul(input [4:0] p, input [7:0] e, input [7:0] c);
    @(posedge core_clk);
    {go, ack, insn_done, halt_insn, wake} <= p;
    {src_evt, src_chg} <= {e, c};
    @(posedge core_clk);
    {go, ack, insn_done, halt_insn, wake} <= 5'h00;
    {src_evt, src_chg} <= 16'h0000;
    #1;
  endtask
  task complete_run;
    if (failures == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #1000000 failures++;
    complete_run;
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1;
    rdc(`ISC_ADDR_USP, 0);
    rdc(`ISC_ADDR_ISP, 0);
    wrr(`ISC_ADDR_IEN, 16'h00FF);
    r = 8'h86;
    pul(5'h00, r, 0);
    chk(irq_req, 0);
    repeat (4) begin
      pul(5'h04, 0, 0);
      chk(irq_req, 1);
      pul(5'h08, 0, 0);
      chk(ack_vec_ff, first(r));
      r = r & ~(8'h01 << first(r));
      rdc(`ISC_ADDR_IRQ, r);
      rdc(`ISC_ADDR_ACK, {8'h00, (r == 0) ? 8'h00 : first(r)});
      r = r & ~(8'h01 << first(r));
      rdc(`ISC_ADDR_IRQ, r);
      wrr(`ISC_ADDR_IRQ, 0);
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      r = seed[7:0] | 8'h01;
      pul(5'h00, r, 0);
    end
    wrr(`ISC_ADDR_IRQ, 0);
    pul(5'h00, 0, 8'h08);
    rdc(`ISC_ADDR_IRQ, 16'h0008);
    wrr(`ISC_ADDR_IRQ, 16'h00F7);
    rdc(`ISC_ADDR_IRQ, 0);
    wrr(`ISC_ADDR_CC1, 1);
    chk(stop_mode, 0);
    wrr(`ISC_ADDR_PRC, 4);
    wrr(`ISC_ADDR_USP, 16'h0400);
    wrr(`ISC_ADDR_CC1, 1);
    chk(stop_mode, 0);
    wrr(`ISC_ADDR_PRC, 4);
    wrr(`ISC_ADDR_CC1, 1);
    chk({stop_mode, cpu_clk_en}, 2'b10);
    repeat (5) @(posedge core_clk);
    #1 chk({per_clk_en, subdiv_clk_en, port_hold}, 3'b001);
    pul(5'h01, 0, 0);
    chk(stop_mode, 0);
    wrr(`ISC_ADDR_PRC, 4);
    wrr(`ISC_ADDR_CC0, 16'h0020);
    chk(xout_en, 0);
    pul(5'h10, 0, 0);
    for (i = 0; i < 20 && nmi_req !== 1'b1; i++) #50;
    chk(nmi_req, 1);
    rdc(`ISC_ADDR_P8, 0);
    wrr(`ISC_ADDR_PRC, 4);
    wrr(`ISC_ADDR_CC1, 1);
    chk(stop_mode, 0);
    pul(5'h02, 0, 0);
    chk(wait_mode, 1);
    chk({cpu_clk_en, port_hold, per_clk_en, subdiv_clk_en}, 4'hF);
    pul(5'h01, 0, 0);
    chk(wait_mode, 0);
    chk(int_out, 0);
    wrr(`ISC_ADDR_CFG, 1);
    chk(int_out, 1);
    wrr(`ISC_ADDR_ICLR, 7);
    chk(int_out, 0);
    complete_run;
  end
endmodule // isc_core_tb
`default_nettype wire
